// ==== shared/cvafs_pkg.sv ====
// Constants for the component video adjust and fast switch block
package cvafs_pkg;
  // ==========================================================
  // Register subaddresses
  localparam logic [7:0] ADDR_CTRL = 8'h29;
  localparam logic [7:0] ADDR_BRI  = 8'h2a;
  localparam logic [7:0] ADDR_CON  = 8'h2b;
  localparam logic [7:0] ADDR_SAT  = 8'h2c;
  // ==========================================================
  // Control register field positions
  localparam int CTRL_SW_EN_BIT = 7;
  localparam int CTRL_POL_BIT   = 6;
  localparam int CTRL_FSWDL_LSB = 4;
  localparam int CTRL_PEAK_BIT  = 3;
  localparam int CTRL_CPDL_LSB  = 0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BRI  = 8'h80;
  localparam logic [7:0] RST_CON  = 8'h40;
  localparam logic [7:0] RST_SAT  = 8'h40;
  // ==========================================================
  // Arithmetic and alignment
  localparam int         GAIN_SHIFT  = 6;
  localparam logic [7:0] BRI_NOMINAL = 8'h80;
  localparam logic [7:0] CHROMA_ZERO = 8'h80;
  localparam int         PEAK_SHIFT  = 4;
  localparam int         LINE_DEPTH  = 32;
  localparam int         BASE_TAP    = 18;
  localparam int         FIFO_DEPTH  = 4;
endpackage

// ==== tb/cvafs_src_model.sv ====
// Pixel source model feeding composite and component words
`timescale 1ns/10ps
module cvafs_src_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_coarse,
  input  wire logic [7:0] i_budget,
  input  wire logic       i_ready,
  output logic            o_valid,
  output logic      [7:0] o_cvbs_y,
  output logic      [7:0] o_cvbs_c,
  output logic      [7:0] o_comp_y,
  output logic      [7:0] o_comp_c,
  output logic            o_sel
);
  logic [32:0] word_r = 33'h0_0000_0000;
  logic        take;
  logic        rst_s;
  logic [7:0]  bud;
  int          sent = 0;
  initial o_valid = 1'b0;
  assign {o_sel, o_comp_c, o_comp_y, o_cvbs_c, o_cvbs_y} = word_r;
  // ====================
  // Handshake
  // Same clock as the decoder, so pixel switching stays legal
  always @(posedge i_clk_sys) begin
    take = o_valid && i_ready;
    rst_s = i_reset;
    bud = i_budget;
    #1;
    if (take) sent++;
    if (rst_s) begin
      o_valid = 1'b0;
      sent = 0;
    end else if (take || !o_valid) begin
      if (sent < int'(bud) && $urandom_range(3) != 0) begin
        word_r = 33'({$urandom, $urandom});
        // Coarse luma keeps the peaking term an exact sixteenth
        if (i_coarse) word_r[23:16] = word_r[23:16] & 8'hf0;
        o_valid = 1'b1;
      end else begin
        // Idle lines toggle so a stale word is never mistaken for data
        word_r = ~word_r;
        o_valid = 1'b0;
      end
    end
  end
endmodule // cvafs_src_model

// ==== tb/tb.sv ====
// Self-checking bench for the component adjust and fast switch block
`timescale 1ns/10ps
`define CHK(act, exp) begin \
  num_checks++; \
  if ((act) !== (exp)) begin \
    error_cnt++; \
    $display("FAIL t=%0t act=%h exp=%h", $time, act, exp); \
  end \
end
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, cy, cc, py, pc, oy, oc;
  logic        pv, pr, ov, osrc, sel;
  logic        ordy = 1'b0;
  logic        coarse = 1'b0;
  logic        stall = 1'b0;
  logic        full_seen = 1'b0;
  logic [7:0]  budget = 8'h00;
  logic [7:0]  ctrl, bri, con, sat;
  logic [32:0] hist[$];
  int          error_cnt = 0;
  int          num_checks = 0;
  int          out_cnt = 0;
  // ====================
  // Clock, design and source
  initial forever #25 clk = ~clk;
  cvafs_top dut_u (.i_clk_sys(clk), .i_reset(rst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_pix_valid(pv), .o_pix_ready(pr), .i_cvbs_y(cy), .i_cvbs_c(cc),
    .i_comp_y(py), .i_comp_c(pc), .i_pixel_source_select_input(sel),
    .o_pix_valid(ov), .i_out_ready(ordy), .o_pix_y(oy), .o_pix_c(oc),
    .o_pix_src(osrc));
  cvafs_src_model src_u (.i_clk_sys(clk), .i_reset(rst),
    .i_coarse(coarse), .i_budget(budget), .i_ready(pr), .o_valid(pv),
    .o_cvbs_y(cy), .o_cvbs_c(cc), .o_comp_y(py), .o_comp_c(pc),
    .o_sel(sel));
  // ====================
  // Reference model
  function automatic logic [32:0] wd(int i);
    if (i < 0) return 33'h0_8000_8000;
    return hist[i];
  endfunction
  function automatic int fy(int i);
    logic [32:0] w;
    w = wd(i);
    return int'(w[23:16]);
  endfunction
  function automatic int clip(int v);
    return v < 0 ? 0 : (v > 255 ? 255 : v);
  endfunction
  task automatic check_pix();
    int n, pcx, yc, ccx, ey, ec;
    logic [32:0] w, ws, wc;
    logic es;
    n = out_cnt;
    out_cnt++;
    pcx = n - 18 - 4 * int'($signed(ctrl[2:0]));
    w = wd(pcx);
    ws = wd(pcx - int'($signed(ctrl[5:4])));
    wc = wd(n - 18);
    yc = int'(w[23:16]);
    if (ctrl[3]) yc = clip(yc + ((2 * yc - fy(pcx - 1) - fy(pcx + 1)) >>> 4));
    yc = clip(((yc * int'($signed(con))) >>> 6) + int'(bri) - 128);
    ccx = (int'(w[31:24]) - 128) * int'($signed(sat));
    ccx = clip((ccx >>> 6) + 128);
    es = ctrl[7] ? (ws[32] ^ ctrl[6]) : ctrl[6];
    ey = es ? yc : int'(wc[7:0]);
    ec = es ? ccx : int'(wc[15:8]);
    `CHK(osrc, es)
    `CHK(oy, 8'(ey))
    `CHK(oc, 8'(ec))
  endtask
  always @(posedge clk) begin
    if (!rst && pv && pr) hist.push_back({sel, pc, py, cc, cy});
    if (!rst && ov && ordy) check_pix();
    if (pr === 1'b0 && stall) full_seen = 1'b1;
  end
  // Downstream stalls at random so output holding is exercised
  always @(posedge clk) begin
    automatic logic s = stall;
    #1;
    ordy = !s && ($urandom_range(3) != 0);
  end
  // ====================
  // Tasks
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
  endtask
  task automatic reg_chk(logic [7:0] a, logic [7:0] d);
    addr = a;
    repeat (2) tick();
    `CHK(rdata, d)
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic run(int i);
    logic [7:0] rv[4];
    logic [7:0] v[4];
    rv = '{cvafs_pkg::RST_CTRL, cvafs_pkg::RST_BRI, cvafs_pkg::RST_CON,
           cvafs_pkg::RST_SAT};
    budget = 8'h00;
    rst = 1'b1;
    hist.delete();
    out_cnt = 0;
    repeat (10) tick();
    rst = 1'b0;
    ctrl = {i[0] ^ i[3], i[1] ^ i[4], i[4:3], i[2] & i[3], i[2:0]};
    // Some runs pin the gains to their corner codes
    bri = (i % 4 == 1) ? 8'h80 : 8'($urandom);
    con = (i % 4 == 1) ? 8'h40 : ((i % 4 == 2) ? 8'h00 : 8'($urandom));
    sat = (i % 4 == 1) ? 8'hc0 : ((i % 4 == 2) ? 8'h00 : 8'($urandom));
    v = '{ctrl, bri, con, sat};
    for (int k = 0; k < 4; k++) begin
      if (i == 0) reg_chk(cvafs_pkg::ADDR_CTRL + 8'(k), rv[k]);
      reg_wr(cvafs_pkg::ADDR_CTRL + 8'(k), v[k]);
      reg_chk(cvafs_pkg::ADDR_CTRL + 8'(k), v[k]);
    end
    reg_wr(8'h2d, 8'hff);
    reg_chk(8'h2d, 8'h00);
    coarse = ctrl[3];
    budget = 8'h30;
    if (i == 9) begin
      repeat (5) tick();
      stall = 1'b1;
      full_seen = 1'b0;
      repeat (30) tick();
      `CHK(full_seen, 1'b1)
      stall = 1'b0;
    end
    for (int t = 0; t < 3000 && out_cnt < 48; t++) tick();
    `CHK(out_cnt, 48)
  endtask
  // ====================
  // Main sequence and watchdog
  initial begin
    void'($urandom(14197));
    repeat (10) tick();
    for (int i = 0; i < 32; i++) run(i);
    end_sim();
  end
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule // tb

// ==== verilog/cvafs_fifo.sv ====
// Small pixel FIFO with valid and ready on both sides
`timescale 1ns/10ps
module cvafs_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
    $error("cvafs_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             rdy_r, rdy_nxt;
  logic             push, pop;

  // ==========================================================
  // Pointer and count
  always_comb begin
    push    = i_in_valid && rdy_r;
    pop     = (cnt_r != '0) && i_out_ready;
    wr_nxt  = push ? AW'(wr_r + 1'b1) : wr_r;
    rd_nxt  = pop ? AW'(rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
    // Registered ready keeps the source path short; costs no space
    rdy_nxt = (cnt_nxt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_r[wr_r] <= i_in_data;
    end
  end

  assign o_in_ready  = rdy_r;
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rd_r];
endmodule // cvafs_fifo

// ==== verilog/cvafs_top.sv ====
// Component video delay, fast switch and luma/chroma adjust
//
// Contract
// - With switching enabled each output pixel follows the select input.
// - Polarity 0 maps select low to composite, 1 inverts that mapping.
// - With switching disabled the polarity bit statically picks the source.
// - A 2-bit code delays the select by 0, +1, -2 or -1 pixels.
// - The peaking bit adds a small luma boost around 5 MHz, else none.
// - A 3-bit code shifts component video in 4-pixel steps, -16 to +12.
// - Brightness adds an unsigned offset where 128 is nominal.
// - Contrast is a signed gain in 1/64 steps, 64 being unity.
// - Saturation is a signed chroma gain in 1/64 steps, 64 being unity.
`timescale 1ns/10ps
module cvafs_top #(
  parameter int FIFO_DEPTH = cvafs_pkg::FIFO_DEPTH
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_pix_valid,
  output logic            o_pix_ready,
  input  wire logic [7:0] i_cvbs_y,
  input  wire logic [7:0] i_cvbs_c,
  input  wire logic [7:0] i_comp_y,
  input  wire logic [7:0] i_comp_c,
  input  wire logic       i_pixel_source_select_input,
  output logic            o_pix_valid,
  input  wire logic       i_out_ready,
  output logic      [7:0] o_pix_y,
  output logic      [7:0] o_pix_c,
  output logic            o_pix_src
);
  localparam int DEPTH = cvafs_pkg::LINE_DEPTH;
  localparam int BASE  = cvafs_pkg::BASE_TAP;
  localparam int WW    = 33;

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("cvafs_top: FIFO_DEPTH must be at least 2");
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // ==========================================================
  // Register file
  logic [7:0] ctrl_r, ctrl_nxt, bri_r, bri_nxt;
  logic [7:0] con_r, con_nxt, sat_r, sat_nxt, rdata_r, rdata_nxt;

  always_comb begin
    ctrl_nxt = ctrl_r;
    bri_nxt  = bri_r;
    con_nxt  = con_r;
    sat_nxt  = sat_r;
    if (i_reg_wr) begin
      case (i_reg_addr)
        cvafs_pkg::ADDR_CTRL: ctrl_nxt = i_reg_wdata;
        cvafs_pkg::ADDR_BRI:  bri_nxt  = i_reg_wdata;
        cvafs_pkg::ADDR_CON:  con_nxt  = i_reg_wdata;
        cvafs_pkg::ADDR_SAT:  sat_nxt  = i_reg_wdata;
        default: ;
      endcase
    end
    case (i_reg_addr)
      cvafs_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
      cvafs_pkg::ADDR_BRI:  rdata_nxt = bri_r;
      cvafs_pkg::ADDR_CON:  rdata_nxt = con_r;
      cvafs_pkg::ADDR_SAT:  rdata_nxt = sat_r;
      default:              rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ctrl_r  <= cvafs_pkg::RST_CTRL;
      bri_r   <= cvafs_pkg::RST_BRI;
      con_r   <= cvafs_pkg::RST_CON;
      sat_r   <= cvafs_pkg::RST_SAT;
      rdata_r <= 8'h00;
    end else begin
      ctrl_r  <= ctrl_nxt;
      bri_r   <= bri_nxt;
      con_r   <= con_nxt;
      sat_r   <= sat_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  logic       sw_en, pol, peak_en;
  logic [1:0] fswdl;
  logic [2:0] cpdl;
  assign sw_en   = ctrl_r[cvafs_pkg::CTRL_SW_EN_BIT];
  assign pol     = ctrl_r[cvafs_pkg::CTRL_POL_BIT];
  assign peak_en = ctrl_r[cvafs_pkg::CTRL_PEAK_BIT];
  assign fswdl   = ctrl_r[cvafs_pkg::CTRL_FSWDL_LSB +: 2];
  assign cpdl    = ctrl_r[cvafs_pkg::CTRL_CPDL_LSB +: 3];

  // ==========================================================
  // Input FIFO
  logic [WW-1:0] fifo_dout;
  logic          fifo_valid, adv, pop;
  logic          out_valid_r, out_valid_nxt, s1_valid_r, s1_valid_nxt;

  // Whole pipeline stalls together; back-pressure reaches the FIFO
  assign adv = !out_valid_r || i_out_ready;
  assign pop = adv && fifo_valid;

  cvafs_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_in_valid  (i_pix_valid),
    .o_in_ready  (o_pix_ready),
    .i_in_data   ({i_pixel_source_select_input, i_comp_c, i_comp_y,
                   i_cvbs_c, i_cvbs_y}),
    .o_out_valid (fifo_valid),
    .i_out_ready (adv),
    .o_out_data  (fifo_dout)
  );

  // ==========================================================
  // Delay lines, index 0 newest
  logic [7:0]  ly_r [DEPTH];
  logic [7:0]  ly_nxt [DEPTH];
  logic [7:0]  lc_r [DEPTH];
  logic [7:0]  lc_nxt [DEPTH];
  logic        lf_r [DEPTH];
  logic        lf_nxt [DEPTH];
  logic [15:0] lv_r [BASE+1];
  logic [15:0] lv_nxt [BASE+1];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_line
      if (gi == 0) begin : g_head
        assign ly_nxt[gi] = pop ? fifo_dout[23:16] : ly_r[gi];
        assign lc_nxt[gi] = pop ? fifo_dout[31:24] : lc_r[gi];
        assign lf_nxt[gi] = pop ? fifo_dout[32] : lf_r[gi];
      end else begin : g_tail
        assign ly_nxt[gi] = pop ? ly_r[gi-1] : ly_r[gi];
        assign lc_nxt[gi] = pop ? lc_r[gi-1] : lc_r[gi];
        assign lf_nxt[gi] = pop ? lf_r[gi-1] : lf_r[gi];
      end
      if (gi <= BASE) begin : g_cvbs
        if (gi == 0) begin : g_vh
          assign lv_nxt[gi] = pop ? fifo_dout[15:0] : lv_r[gi];
        end else begin : g_vt
          assign lv_nxt[gi] = pop ? lv_r[gi-1] : lv_r[gi];
        end
      end
      always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
          ly_r[gi] <= 8'h00;
          lc_r[gi] <= cvafs_pkg::CHROMA_ZERO;
          lf_r[gi] <= 1'b0;
        end else begin
          ly_r[gi] <= ly_nxt[gi];
          lc_r[gi] <= lc_nxt[gi];
          lf_r[gi] <= lf_nxt[gi];
        end
      end
      if (gi <= BASE) begin : g_cvff
        always_ff @(posedge i_clk_sys) begin
          if (i_reset) begin
            lv_r[gi] <= {cvafs_pkg::CHROMA_ZERO, 8'h00};
          end else begin
            lv_r[gi] <= lv_nxt[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Tap selection and peaking
  logic signed [6:0]  comp_off;
  logic        [4:0]  comp_tap, fsw_tap;
  logic signed [11:0] hp, pk;
  logic        [7:0]  ty, s1_y_nxt;

  always_comb begin
    comp_off = {{2{cpdl[2]}}, cpdl, 2'b00};
    comp_tap = 5'(7'(BASE) + comp_off);
    fsw_tap  = 5'(comp_tap + {{3{fswdl[1]}}, fswdl});
    ty       = ly_nxt[comp_tap];
    hp = 12'(2 * $signed({4'h0, ty}))
       - $signed({4'h0, ly_nxt[comp_tap - 5'd1]})
       - $signed({4'h0, ly_nxt[comp_tap + 5'd1]});
    pk = $signed({4'h0, ty}) + (hp >>> cvafs_pkg::PEAK_SHIFT);
    if (!peak_en) begin
      s1_y_nxt = ty;
    end else if (pk < 0) begin
      s1_y_nxt = 8'h00;
    end else if (pk > 255) begin
      s1_y_nxt = 8'hff;
    end else begin
      s1_y_nxt = pk[7:0];
    end
  end

  logic [7:0]  s1_y_r, s1_c_r;
  logic [15:0] s1_v_r;
  logic        s1_f_r;

  always_comb begin
    s1_valid_nxt  = adv ? pop : s1_valid_r;
    out_valid_nxt = adv ? s1_valid_r : out_valid_r;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s1_valid_r <= 1'b0;
      s1_y_r     <= 8'h00;
      s1_c_r     <= cvafs_pkg::CHROMA_ZERO;
      s1_v_r     <= {cvafs_pkg::CHROMA_ZERO, 8'h00};
      s1_f_r     <= 1'b0;
    end else begin
      s1_valid_r <= s1_valid_nxt;
      if (adv) begin
        s1_y_r <= s1_y_nxt;
        s1_c_r <= lc_nxt[comp_tap];
        s1_v_r <= lv_nxt[BASE];
        s1_f_r <= lf_nxt[fsw_tap];
      end
    end
  end

  // ==========================================================
  // Gains, offset, clipping and source select
  logic signed [16:0] yp, cp;
  logic signed [11:0] ys, cs;
  logic        [7:0]  y_adj, c_adj, oy_nxt, oc_nxt;
  logic               src_nxt;
  logic        [7:0]  oy_r, oc_r;
  logic               src_r;

  always_comb begin
    yp = $signed({1'b0, s1_y_r}) * $signed(con_r);
    ys = 12'(yp >>> cvafs_pkg::GAIN_SHIFT)
       + $signed({4'h0, bri_r}) - $signed({4'h0, cvafs_pkg::BRI_NOMINAL});
    if (ys < 0) y_adj = 8'h00;
    else if (ys > 255) y_adj = 8'hff;
    else y_adj = ys[7:0];
    cp = ($signed({1'b0, s1_c_r}) - $signed({1'b0, cvafs_pkg::CHROMA_ZERO}))
       * $signed(sat_r);
    cs = 12'(cp >>> cvafs_pkg::GAIN_SHIFT)
       + $signed({4'h0, cvafs_pkg::CHROMA_ZERO});
    if (cs < 0) c_adj = 8'h00;
    else if (cs > 255) c_adj = 8'hff;
    else c_adj = cs[7:0];
    // Async sources still switch; tearing is the system's concern
    if (sw_en) src_nxt = s1_f_r ^ pol;
    else       src_nxt = pol;
    oy_nxt = src_nxt ? y_adj : s1_v_r[7:0];
    oc_nxt = src_nxt ? c_adj : s1_v_r[15:8];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      out_valid_r <= 1'b0;
      oy_r        <= 8'h00;
      oc_r        <= cvafs_pkg::CHROMA_ZERO;
      src_r       <= 1'b0;
    end else begin
      out_valid_r <= out_valid_nxt;
      if (adv) begin
        oy_r  <= oy_nxt;
        oc_r  <= oc_nxt;
        src_r <= src_nxt;
      end
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_pix_valid = out_valid_r;
  assign o_pix_y     = oy_r;
  assign o_pix_c     = oc_r;
  assign o_pix_src   = src_r;

  // ==========================================================
  // Assertions
  logic step;
  assign step = adv && s1_valid_r;

  a_switch_map: assert property (
    step && sw_en |=> o_pix_src == ($past(s1_f_r) ^ $past(pol)))
    else $error("switch mapping wrong");

  a_static_src: assert property (
    step && !sw_en |=> o_pix_src == $past(pol))
    else $error("static source wrong");

  a_cvbs_pass: assert property (
    adv && s1_valid_r && !src_nxt |=> o_pix_y == $past(s1_v_r[7:0]))
    else $error("composite pixel altered");

  a_comp_tap: assert property (
    (cpdl == 3'b100 |-> comp_tap == 5'd2)
    and (cpdl == 3'b011 |-> comp_tap == 5'd30))
    else $error("component delay tap wrong");

  a_fsw_tap: assert property (
    fswdl == 2'b10 |-> 6'(fsw_tap) + 6'd2 == 6'(comp_tap))
    else $error("select delay wrong");

  a_peak_off: assert property (
    adv && !peak_en |=> s1_y_r == $past(ly_nxt[comp_tap]))
    else $error("peaking active while off");

  a_unity_luma: assert property (
    adv && src_nxt && con_r == 8'h40 && bri_r == 8'h80
    |=> o_pix_y == $past(s1_y_r))
    else $error("unity luma altered");

  a_luma_off: assert property (
    adv && src_nxt && con_r == 8'h00 |=> o_pix_y == $past(bri_r) - 8'h80
      || ($past(bri_r) < 8'h80 && o_pix_y == 8'h00))
    else $error("zero contrast wrong");

  a_colour_off: assert property (
    adv && src_nxt && sat_r == 8'h00 |=> o_pix_c == 8'h80)
    else $error("zero saturation leaves colour");

  a_chroma_inv: assert property (
    adv && src_nxt && sat_r == 8'hc0 && s1_c_r != 8'h00
    |=> o_pix_c == 8'h00 - $past(s1_c_r))
    else $error("inverse chroma wrong");
endmodule // cvafs_top
